// ===== verilog/ddrc_pkg.sv
// Overview of operation
// [RULE1] The two setup words are write-only and reading them gives back no stored value.
// [RULE2] Bits 26 to 24 of setup word zero drive the three-bit PHY frequency-range select.
// [RULE3] Software picks the range code from the memory clock: 100, 101, 110 or 111.
// [RULE4] Software writes only the fixed board values into bits 31:27 and 23:0 of word zero.
// [RULE5] Software writes the setup words while it configures, before memory traffic starts.
// [RULE6] The registers sit in one 4KB page based at 0x100E0000.
// [RULE7] The request side carries 64-bit data and the memory side a 32-bit data bus.
// [RULE8] The request side runs on the interconnect clock, the same one as the register bus.
// [RULE9] The memory side runs on its own clock and all traffic crosses between the two.
// [RULE10] Pending requests wait in a queue of up to 16 entries.
// [RULE11] Read data waits in a buffer of up to 20 beats on its way to the request side.
// [RULE12] Write data waits in a buffer of up to 20 beats on its way to the memory side.
// [RULE13] Two exclusive monitors track two exclusive reservations at the same time.
// [RULE14] The setup words drive static PHY control wires and never touch scheduling.
// [RULE15] Buffers between the clocks are dual-clock FIFOs with synchronised gray pointers.
`default_nettype none
package ddrc_pkg;
  localparam logic [19:0] PAGE_BASE  = 20'h100e0;  // 4KB page index
  localparam logic [11:0] OFF_SETUP0 = 12'h010;
  localparam logic [11:0] OFF_SETUP1 = 12'h014;
  localparam logic [11:0] OFF_STATUS = 12'h018;
  localparam logic [31:0] SETUP_RST  = 32'h0000_0000;
  localparam int          FRQ_LSB    = 24;
  localparam int          FRQ_MSB    = 26;
  localparam int          AXI_W      = 64;
  localparam int          MEM_W      = 32;
  localparam int          ADDR_W     = 32;
  localparam int          CMD_W      = 33;         // {write, address}
  localparam int          CMD_WR_BIT = 32;
  localparam int          CMD_DEPTH  = 16;
  localparam int          CMD_AW     = 4;
  localparam int          DAT_DEPTH  = 20;
  localparam int          DAT_AW     = 5;
  localparam logic [31:0] HI_OFS     = 32'h0000_0004;
  typedef enum logic [1:0] {
    MS_IDLE = 2'b00,
    MS_LO   = 2'b01,
    MS_RESP = 2'b11
  } ddrc_mst_t;
endpackage
`default_nettype wire

// ===== verilog/ddrc_fifo_if.sv
`timescale 1ns/10ps
`default_nettype none
interface ddrc_fifo_if #(parameter int W = 8);
  logic         wr_valid;
  logic         wr_ready;
  logic [W-1:0] wr_data;
  logic         rd_valid;
  logic         rd_ready;
  logic [W-1:0] rd_data;
  modport fifo (input wr_valid, wr_data, rd_ready, output wr_ready, rd_valid, rd_data);
  modport prod (output wr_valid, wr_data, input wr_ready);
  modport cons (output rd_ready, input rd_valid, rd_data);
endinterface
`default_nettype wire

// ===== verilog/ddrc_afifo.sv
`timescale 1ns/10ps
`default_nettype none
module ddrc_afifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input wire logic  wclk,    // filling clock
  input wire logic  wrst_n,  // filling side reset
  input wire logic  rclk,    // draining clock
  input wire logic  rrst_n,  // draining side reset
  ddrc_fifo_if.fifo f        // both sides
);
  localparam logic [AW:0] CAP = (AW+1)'(DEPTH);

  function automatic logic [AW:0] g2b(input logic [AW:0] g);
    logic [AW:0] b;
    b = g;
    for (int i = AW-1; i >= 0; i--) b[i] = b[i+1] ^ g[i];
    return b;
  endfunction

  function automatic logic [AW:0] b2g(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction

  logic [W-1:0] mem_q [0:(1<<AW)-1];
  logic [AW:0]  wbin_ff, wgray_ff, rbin_ff, rgray_ff;
  logic [AW:0]  rg_s1_ff, rg_s2_ff, wg_s1_ff, wg_s2_ff;
  logic         full_ff, empty_ff;

  wire logic        push     = f.wr_valid && !full_ff;
  wire logic        pop      = f.rd_ready && !empty_ff;
  wire logic [AW:0] nxt_wbin = wbin_ff + (AW+1)'(push);
  wire logic [AW:0] nxt_rbin = rbin_ff + (AW+1)'(pop);

  assign f.wr_ready = !full_ff;
  assign f.rd_valid = !empty_ff;
  assign f.rd_data  = mem_q[rbin_ff[AW-1:0]];

  // fill side: full is judged on a stale read pointer, so it errs safe
  always_ff @(posedge wclk or negedge wrst_n) begin
    if (!wrst_n) begin
      wbin_ff  <= '0;
      wgray_ff <= '0;
      rg_s1_ff <= '0;
      rg_s2_ff <= '0;
      full_ff  <= 1'b0;
    end else begin
      wbin_ff  <= nxt_wbin;
      wgray_ff <= b2g(nxt_wbin);            // [RULE15]
      rg_s1_ff <= rgray_ff;
      rg_s2_ff <= rg_s1_ff;
      full_ff  <= (nxt_wbin - g2b(rg_s2_ff)) >= CAP;
    end
  end

  // storage has no reset
  always_ff @(posedge wclk) begin
    if (push) mem_q[wbin_ff[AW-1:0]] <= f.wr_data;
  end

  // drain side
  always_ff @(posedge rclk or negedge rrst_n) begin
    if (!rrst_n) begin
      rbin_ff  <= '0;
      rgray_ff <= '0;
      wg_s1_ff <= '0;
      wg_s2_ff <= '0;
      empty_ff <= 1'b1;
    end else begin
      rbin_ff  <= nxt_rbin;
      rgray_ff <= b2g(nxt_rbin);            // [RULE15]
      wg_s1_ff <= wgray_ff;
      wg_s2_ff <= wg_s1_ff;
      empty_ff <= nxt_rbin == g2b(wg_s2_ff);
    end
  end

  AST_FIFO_CAP: assert property (@(posedge wclk) disable iff (!wrst_n) // [RULE15]
    (wbin_ff - g2b(rg_s2_ff)) <= CAP)
    else $error("fifo holds more than its depth");
endmodule
`default_nettype wire

// ===== verilog/ddrc_top.sv
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module ddrc_top (
  input  wire logic        pclk,           // bus and request clock
  input  wire logic        presetn,        // async reset, low
  input  wire logic [31:0] paddr,          // apb address
  input  wire logic        psel,           // apb select
  input  wire logic        penable,        // apb enable
  input  wire logic        pwrite,         // apb direction
  input  wire logic [31:0] pwdata,         // apb write data
  output logic      [31:0] prdata,         // apb read data
  output logic             pready,         // apb ready
  output logic             pslverr,        // apb error
  input  wire logic        req_valid,      // request offered
  output logic             req_ready,      // request taken
  input  wire logic        req_write,      // 1 write, 0 read
  input  wire logic        req_excl,       // exclusive access
  input  wire logic        req_id,         // monitor selector
  input  wire logic [31:0] req_addr,       // 8-byte aligned
  input  wire logic [63:0] req_wdata,      // write beat
  output logic             wr_done,        // write accepted pulse
  output logic             wr_exokay,      // exclusive write passed
  output logic             rsp_valid,      // read beat ready
  input  wire logic        rsp_ready,      // read beat taken
  output logic      [63:0] rsp_data,       // read beat
  input  wire logic        mclk,           // memory clock
  output logic             mem_cmd_valid,  // memory word command
  output logic             mem_cmd_write,  // memory direction
  output logic      [31:0] mem_addr,       // memory byte address
  output logic      [31:0] mem_wdata,      // memory write word
  input  wire logic        mem_rvalid,     // memory read word valid
  input  wire logic [31:0] mem_rdata,      // memory read word
  output logic       [2:0] phy_freq_range_select, // phy clock range
  output logic      [31:0] phy_setup0_bits,       // phy static word zero
  output logic      [31:0] phy_setup1_bits        // phy static word one
);
  // crossings
  ddrc_fifo_if #(.W(ddrc_pkg::CMD_W)) cmd_if ();
  ddrc_fifo_if #(.W(ddrc_pkg::AXI_W)) wd_if ();
  ddrc_fifo_if #(.W(ddrc_pkg::AXI_W)) rd_if ();

  // ---------------- register bus, pclk ----------------
  logic        pready_ff;
  logic        pslverr_ff;
  logic [31:0] prdata_ff;
  logic [31:0] setup0_ff;
  logic [31:0] setup1_ff;

  // decode
  wire logic in_page  = paddr[31:12] == ddrc_pkg::PAGE_BASE;  // [RULE6]
  wire logic sel_s0   = in_page && paddr[11:0] == ddrc_pkg::OFF_SETUP0;
  wire logic sel_s1   = in_page && paddr[11:0] == ddrc_pkg::OFF_SETUP1;
  wire logic sel_st   = in_page && paddr[11:0] == ddrc_pkg::OFF_STATUS;
  wire logic hit      = sel_s0 || sel_s1 || sel_st;
  wire logic setup_ph = psel && !penable;
  wire logic done_ph  = psel && penable && pready_ff;
  wire logic wr_s0    = done_ph && pwrite && sel_s0;
  wire logic wr_s1    = done_ph && pwrite && sel_s1;

  // status shows the block's own state
  logic [1:0] mon_vld_ff;
  logic [1:0] qbusy_sync_ff;
  wire logic [31:0] status_word = {26'h0, phy_freq_range_select[0], rsp_valid,
                                   req_ready, qbusy_sync_ff[1], mon_vld_ff};

  // queue-busy flag lives on mclk; two flops before the bus clock reads it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qbusy_sync_ff <= 2'b00;
    end else begin
      qbusy_sync_ff <= {qbusy_sync_ff[0], cmd_if.rd_valid};
    end
  end

  // write-only words read back zero; the value is not meant to be trusted
  wire logic [31:0] nxt_prdata = (sel_st && !pwrite) ? status_word : 32'h0; // [RULE1]

  // zero wait: ready is raised in the setup cycle for the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0;
    end else begin
      pready_ff  <= setup_ph;
      pslverr_ff <= setup_ph && !hit;
      prdata_ff  <= setup_ph ? nxt_prdata : 32'h0;
    end
  end

  // setup words go straight out as static phy wires
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setup0_ff <= ddrc_pkg::SETUP_RST;
      setup1_ff <= ddrc_pkg::SETUP_RST;
    end else begin
      if (wr_s0) setup0_ff <= pwdata;  // [RULE14]
      if (wr_s1) setup1_ff <= pwdata;  // [RULE14]
    end
  end

  assign pready          = pready_ff;
  assign pslverr         = pslverr_ff;
  assign prdata          = prdata_ff;
  assign phy_setup0_bits = setup0_ff;
  assign phy_setup1_bits = setup1_ff;
  // static wires: the phy samples them only while traffic is stopped
  assign phy_freq_range_select = setup0_ff[ddrc_pkg::FRQ_MSB:ddrc_pkg::FRQ_LSB]; // [RULE2]

  // ---------------- request side, pclk ----------------
  logic [31:0] mon_addr_ff [0:1];
  logic        wr_done_ff;
  logic        wr_exokay_ff;

  // request side shares the bus clock
  wire logic acc       = req_valid && req_ready;       // [RULE8]
  wire logic excl_pass = mon_vld_ff[req_id] && mon_addr_ff[req_id] == req_addr;
  wire logic excl_drop = req_write && req_excl && !excl_pass;
  wire logic hit_m0    = mon_vld_ff[0] && mon_addr_ff[0] == req_addr;
  wire logic hit_m1    = mon_vld_ff[1] && mon_addr_ff[1] == req_addr;

  // a failed exclusive write never reaches memory
  assign req_ready        = cmd_if.wr_ready && wd_if.wr_ready;
  assign cmd_if.wr_valid  = acc && !excl_drop;                      // [RULE10]
  assign cmd_if.wr_data   = {req_write, req_addr};
  assign wd_if.wr_valid   = acc && req_write && !excl_drop;          // [RULE12]
  assign wd_if.wr_data    = req_wdata;                               // [RULE7]

  // two monitors; a committed write to a watched address ends each monitor watching it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mon_vld_ff <= 2'b00;
    end else if (acc && req_write && !excl_drop) begin
      mon_vld_ff <= mon_vld_ff & ~{hit_m1, hit_m0};                 // [RULE13]
    end else if (acc && !req_write && req_excl) begin
      mon_vld_ff[req_id] <= 1'b1;                                   // [RULE13]
    end
  end

  // monitor addresses, no reset needed behind the valid bits
  always_ff @(posedge pclk) begin
    if (acc && !req_write && req_excl) mon_addr_ff[req_id] <= req_addr;
  end

  // write answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_done_ff   <= 1'b0;
      wr_exokay_ff <= 1'b0;
    end else begin
      wr_done_ff   <= acc && req_write;
      wr_exokay_ff <= acc && req_write && req_excl && excl_pass;
    end
  end

  assign wr_done         = wr_done_ff;
  assign wr_exokay       = wr_exokay_ff;
  assign rsp_valid       = rd_if.rd_valid;
  assign rsp_data        = rd_if.rd_data;
  assign rd_if.rd_ready  = rsp_ready;

  // ---------------- memory side, mclk ----------------
  logic                     mrst_s1_ff;
  logic                     mrst_n_ff;
  ddrc_pkg::ddrc_mst_t      state_ff;
  logic [ddrc_pkg::CMD_W-1:0] cmd_ff;
  logic                     got_lo_ff;
  logic [31:0]              rlo_ff;
  logic                     mvalid_ff;
  logic                     mwrite_ff;
  logic [31:0]              maddr_ff;
  logic [31:0]              mwdata_ff;

  // reset released in step with mclk, asserted at once
  always_ff @(posedge mclk or negedge presetn) begin
    if (!presetn) begin
      mrst_s1_ff <= 1'b0;
      mrst_n_ff  <= 1'b0;
    end else begin
      mrst_s1_ff <= 1'b1;
      mrst_n_ff  <= mrst_s1_ff;
    end
  end

  // a read only starts when its beat is sure to fit
  wire logic head_wr  = cmd_if.rd_data[ddrc_pkg::CMD_WR_BIT];
  wire logic can_go   = cmd_if.rd_valid && (head_wr ? wd_if.rd_valid : rd_if.wr_ready);
  wire logic start    = state_ff == ddrc_pkg::MS_IDLE && can_go;
  wire logic in_lo    = state_ff == ddrc_pkg::MS_LO;
  wire logic cmd_wr   = cmd_ff[ddrc_pkg::CMD_WR_BIT];
  wire logic rd_last  = state_ff == ddrc_pkg::MS_RESP && got_lo_ff && mem_rvalid;

  assign cmd_if.rd_ready = start;
  assign wd_if.rd_ready  = in_lo && cmd_wr;
  assign rd_if.wr_valid  = rd_last;                                  // [RULE11]
  assign rd_if.wr_data   = {mem_rdata, rlo_ff};                      // [RULE7]

  // sequencer: each 64-bit beat is two 32-bit words, low half first
  always_ff @(posedge mclk or negedge mrst_n_ff) begin
    if (!mrst_n_ff) begin
      state_ff  <= ddrc_pkg::MS_IDLE;
      cmd_ff    <= '0;
      mvalid_ff <= 1'b0;
      mwrite_ff <= 1'b0;
      maddr_ff  <= 32'h0;
      mwdata_ff <= 32'h0;
    end else begin
      mvalid_ff <= 1'b0;
      case (state_ff)
        ddrc_pkg::MS_IDLE: begin
          if (start) begin
            cmd_ff    <= cmd_if.rd_data;
            mvalid_ff <= 1'b1;
            mwrite_ff <= head_wr;
            maddr_ff  <= cmd_if.rd_data[31:0];
            mwdata_ff <= wd_if.rd_data[31:0];                        // [RULE9]
            state_ff  <= ddrc_pkg::MS_LO;
          end
        end
        ddrc_pkg::MS_LO: begin
          mvalid_ff <= 1'b1;
          maddr_ff  <= cmd_ff[31:0] + ddrc_pkg::HI_OFS;
          mwdata_ff <= wd_if.rd_data[63:32];
          state_ff  <= cmd_wr ? ddrc_pkg::MS_IDLE : ddrc_pkg::MS_RESP;
        end
        ddrc_pkg::MS_RESP: begin
          if (rd_last) state_ff <= ddrc_pkg::MS_IDLE;
        end
        default: state_ff <= ddrc_pkg::MS_IDLE;
      endcase
    end
  end

  // read words are assumed to return in order
  always_ff @(posedge mclk or negedge mrst_n_ff) begin
    if (!mrst_n_ff) begin
      got_lo_ff <= 1'b0;
      rlo_ff    <= 32'h0;
    end else if (state_ff == ddrc_pkg::MS_RESP && mem_rvalid) begin
      got_lo_ff <= !got_lo_ff;
      if (!got_lo_ff) rlo_ff <= mem_rdata;
    end
  end

  assign mem_cmd_valid = mvalid_ff;
  assign mem_cmd_write = mwrite_ff;
  assign mem_addr      = maddr_ff;
  assign mem_wdata     = mwdata_ff;

  // ---------------- buffers across the clocks ----------------
  // queue of pending requests
  ddrc_afifo #(.W(ddrc_pkg::CMD_W), .DEPTH(ddrc_pkg::CMD_DEPTH), // [RULE10]
               .AW(ddrc_pkg::CMD_AW)) u_cmd (
    .wclk   (pclk),
    .wrst_n (presetn),
    .rclk   (mclk),
    .rrst_n (mrst_n_ff),
    .f      (cmd_if)
  );

  // write beats
  ddrc_afifo #(.W(ddrc_pkg::AXI_W), .DEPTH(ddrc_pkg::DAT_DEPTH), // [RULE12]
               .AW(ddrc_pkg::DAT_AW)) u_wd (
    .wclk   (pclk),
    .wrst_n (presetn),
    .rclk   (mclk),
    .rrst_n (mrst_n_ff),
    .f      (wd_if)
  );

  // read beats
  ddrc_afifo #(.W(ddrc_pkg::AXI_W), .DEPTH(ddrc_pkg::DAT_DEPTH), // [RULE11]
               .AW(ddrc_pkg::DAT_AW)) u_rd (
    .wclk   (mclk),
    .wrst_n (mrst_n_ff),
    .rclk   (pclk),
    .rrst_n (presetn),
    .f      (rd_if)
  );

  // ---------------- checks ----------------
  sequence seq_s0_write;
    wr_s0;
  endsequence

  sequence seq_lo_word;
    mem_cmd_valid && in_lo;
  endsequence

  AST_FREQ_SEL: assert property (@(posedge pclk) disable iff (!presetn) // [RULE2]
    seq_s0_write |=> phy_freq_range_select == $past(pwdata[26:24]))
    else $error("frequency select does not follow word zero");

  AST_WO_READ: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
    setup_ph && !pwrite && (sel_s0 || sel_s1) |=> pready && prdata == 32'h0)
    else $error("setup word read returned data");

  AST_OFF_PAGE: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
    setup_ph && !in_page |=> pready && pslverr)
    else $error("access outside page not refused");

  AST_PHY_STATIC: assert property (@(posedge pclk) disable iff (!presetn) // [RULE14]
    !wr_s1 |=> $stable(phy_setup1_bits))
    else $error("static phy word changed without a write");

  AST_EXCL_FAIL: assert property (@(posedge pclk) disable iff (!presetn) // [RULE13]
    acc && excl_drop |-> !wd_if.wr_valid && !cmd_if.wr_valid ##1 wr_done && !wr_exokay)
    else $error("failed exclusive write went through");

  AST_MEM_PAIR: assert property (@(posedge mclk) disable iff (!mrst_n_ff) // [RULE7]
    seq_lo_word |=> mem_cmd_valid && mem_addr == $past(mem_addr) + 32'h4)
    else $error("high word does not follow low word");

  AST_RD_PUSH: assert property (@(posedge mclk) disable iff (!mrst_n_ff) // [RULE11]
    rd_last |-> rd_if.wr_ready ##1 state_ff == ddrc_pkg::MS_IDLE)
    else $error("read beat pushed into full buffer");
endmodule
`default_nettype wire

// ===== verification/ddrc_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module ddrc_mem_model (
  input  wire logic        mclk,       // memory clock
  input  wire logic        slow,       // stretch read latency
  input  wire logic        cmd_valid,  // word command
  input  wire logic        cmd_write,  // 1 write
  input  wire logic [31:0] addr,       // byte address
  input  wire logic [31:0] wdata,      // write word
  output logic             rvalid,     // read word pulse
  output logic      [31:0] rdata       // read word
);
  logic [31:0] mem_q [logic [31:0]];
  logic [31:0] rd_q [$];
  int          wait_cnt;

  initial begin
    rvalid   = 1'b0;
    rdata    = 32'h0000_0000;
    wait_cnt = 0;
  end

  // words answered in command order; idle bus toggles so a stale word never looks valid
  always @(posedge mclk) begin
    if (cmd_valid && cmd_write) begin
      mem_q[addr] = wdata;
    end else if (cmd_valid) begin
      rd_q.push_back(mem_q.exists(addr) ? mem_q[addr] : ~addr);
    end
    rvalid <= 1'b0;
    rdata  <= ~rdata;
    if (rd_q.size() != 0 && wait_cnt >= (slow ? 5 : 0)) begin
      rvalid   <= 1'b1;
      rdata    <= rd_q.pop_front();
      wait_cnt <= 0;
    end else if (rd_q.size() != 0) begin
      wait_cnt <= wait_cnt + 1;
    end
  end
endmodule
`default_nettype wire

// ===== verification/tb_ddrc_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_ddrc_top;
  typedef struct {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        err;
    logic [2:0]  frq;
    logic [31:0] exp0;
    logic [31:0] exp1;
  } ddrc_row_t;
  localparam logic [31:0] BOARD_BITS = 32'h0800_00a5;
  localparam logic [31:0] FILL = 32'h6000_0100;
  localparam logic [31:0] A = 32'h6000_0800;
  localparam logic [31:0] B = 32'h6000_0808;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, req_addr, mem_addr, mem_wdata, mem_rdata;
  logic        req_valid, req_ready, req_write, req_excl, req_id, wr_done, wr_exokay;
  logic        rsp_valid, rsp_ready, mclk, mem_cmd_valid, mem_cmd_write, mem_rvalid;
  logic [63:0] req_wdata, rsp_data;
  logic [2:0]  phy_freq_range_select;
  logic [31:0] phy_setup0_bits, phy_setup1_bits;
  logic        mclk_run, slow;
  int          fails, cmp_count;
  ddrc_row_t   rows [7];

  ddrc_top i_ddrc_top (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_excl(req_excl), .req_id(req_id), .req_addr(req_addr),
    .req_wdata(req_wdata), .wr_done(wr_done), .wr_exokay(wr_exokay),
    .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_data(rsp_data), .mclk(mclk),
    .mem_cmd_valid(mem_cmd_valid), .mem_cmd_write(mem_cmd_write), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
    .phy_freq_range_select(phy_freq_range_select), .phy_setup0_bits(phy_setup0_bits),
    .phy_setup1_bits(phy_setup1_bits)
  );

  ddrc_mem_model i_ddrc_mem_model (
    .mclk(mclk), .slow(slow), .cmd_valid(mem_cmd_valid), .cmd_write(mem_cmd_write),
    .addr(mem_addr), .wdata(mem_wdata), .rvalid(mem_rvalid), .rdata(mem_rdata)
  );

  // memory clock stops when asked, to freeze the draining side
  initial pclk = 1'b0;
  always #10 pclk = ~pclk;
  initial mclk = 1'b0;
  always #17.3 if (mclk_run) mclk = ~mclk;

  function automatic logic [31:0] reg_at(input logic [11:0] off);
    return {ddrc_pkg::PAGE_BASE, off};
  endfunction
  function automatic logic [31:0] w0(input logic [2:0] c);
    return BOARD_BITS | {5'h00, c, 24'h00_0000};
  endfunction
  function automatic logic [63:0] fill_d(input int k);
    return {16'hd0d0, 16'(k), 16'h0e0e, 16'(k)};
  endfunction

  task automatic print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic timeout;
    fails++;
    $display("[FAIL] handshake wait expected 1 seen 0");
    print_verdict();
  endtask
  task automatic chk(input string name, input logic [63:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // request held until pready is sampled high; psel stays up for a following transfer
  task automatic apb(input logic wr, input logic [31:0] a, d, output logic [31:0] rd,
                     output logic er);
    int n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) timeout();
    rd = prdata;
    er = pslverr;
  endtask
  task automatic apb_idle;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic req_put(input logic wr, ex, id, input logic [31:0] a, input logic [63:0] d);
    int n = 0;
    req_valid <= 1'b1;
    req_write <= wr;
    req_excl  <= ex;
    req_id    <= id;
    req_addr  <= a;
    req_wdata <= d;
    do begin
      @(posedge pclk);
      n++;
    end while (req_ready !== 1'b1 && n < 2000);
    if (req_ready !== 1'b1) timeout();
  endtask
  task automatic req_end;
    req_valid <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr_chk(input logic ex, id, input logic [31:0] a, input logic [63:0] d,
                        input logic ok);
    req_put(1'b1, ex, id, a, d);
    req_end();
    chk("wr_done", wr_done, 1'b1);
    chk("wr_exokay", wr_exokay, ok);
  endtask
  task automatic rsp_take(output logic [63:0] d);
    int n = 0;
    rsp_ready <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 2000);
    if (rsp_valid !== 1'b1) timeout();
    d = rsp_data;
  endtask
  task automatic rd_one(input logic ex, id, input logic [31:0] a, output logic [63:0] d);
    req_put(1'b0, ex, id, a, 64'h0);
    req_end();
    rsp_take(d);
    rsp_ready <= 1'b0;
  endtask
  task automatic mem_chk(input logic [31:0] a, input logic [63:0] d);
    int n = 0;
    while (!i_ddrc_mem_model.mem_q.exists(a + 32'h4) && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 2000) timeout();
    chk("mem low word", i_ddrc_mem_model.mem_q[a], d[31:0]);
    chk("mem high word", i_ddrc_mem_model.mem_q[a + 32'h4], d[63:32]);
  endtask

  // main sequence: setup words first, then memory traffic
  initial begin
    logic [31:0] rd;
    logic        er;
    logic [63:0] d;
    int          n;
    int          idle;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {req_valid, req_write, req_excl, req_id, req_addr, req_wdata, rsp_ready} = '0;
    {fails, cmp_count, slow} = '0;
    mclk_run = 1'b1;
    for (int i = 0; i < 4; i++) begin
      rows[i] = '{reg_at(ddrc_pkg::OFF_SETUP0), w0(3'(4 + i)), 1'b0, 3'(4 + i),
                  w0(3'(4 + i)), 32'h0000_0000};
    end
    rows[4] = '{reg_at(ddrc_pkg::OFF_SETUP1), 32'h1234_5678, 1'b0, 3'b111, w0(3'b111),
                32'h1234_5678};
    rows[5] = '{reg_at(12'h020), 32'hffff_ffff, 1'b1, 3'b111, w0(3'b111), 32'h1234_5678};
    rows[6] = '{{20'h100e1, ddrc_pkg::OFF_SETUP0}, 32'h0, 1'b1, 3'b111, w0(3'b111),
                32'h1234_5678};
    repeat (5) @(posedge pclk);
    chk("rst setup0", phy_setup0_bits, ddrc_pkg::SETUP_RST);
    chk("rst freq", phy_freq_range_select, 3'b000);
    presetn <= 1'b1;
    repeat (12) @(posedge pclk);
    foreach (rows[i]) begin
      apb(1'b1, rows[i].addr, rows[i].wdata, rd, er);
      chk("wr err", er, rows[i].err);
      apb(1'b0, rows[i].addr, 32'h0, rd, er);
      chk("rd err", er, rows[i].err);
      chk("rd data", rd, 32'h0);
      apb_idle();
      @(posedge pclk);
      chk("freq sel", phy_freq_range_select, rows[i].frq);
      chk("setup0", phy_setup0_bits, rows[i].exp0);
      chk("setup1", phy_setup1_bits, rows[i].exp1);
    end
    // one beat split into two memory words, then two monitors at once
    wr_chk(1'b0, 1'b0, A, 64'h1111_2222_3333_4444, 1'b0);
    mem_chk(A, 64'h1111_2222_3333_4444);
    wr_chk(1'b0, 1'b0, B, 64'h5555_6666_7777_8888, 1'b0);
    rd_one(1'b1, 1'b0, A, d);
    chk("excl rd a", d, 64'h1111_2222_3333_4444);
    rd_one(1'b1, 1'b1, B, d);
    chk("excl rd b", d, 64'h5555_6666_7777_8888);
    // status: both monitors set, queue idle, request side free, select bit 0 high
    apb(1'b0, reg_at(ddrc_pkg::OFF_STATUS), 32'h0, rd, er);
    apb_idle();
    chk("status err", er, 1'b0);
    chk("status", rd, 32'h0000_002b);
    wr_chk(1'b1, 1'b1, B, 64'h0bbb_0bbb_0bbb_0bbb, 1'b1);
    wr_chk(1'b1, 1'b0, A, 64'h0aaa_0aaa_0aaa_0aaa, 1'b1);
    wr_chk(1'b1, 1'b0, A, 64'hdead_dead_dead_dead, 1'b0);
    rd_one(1'b0, 1'b0, A, d);
    chk("refused excl", d, 64'h0aaa_0aaa_0aaa_0aaa);
    // frozen memory clock: the queue must refuse after exactly its depth
    repeat (30) @(posedge pclk);
    mclk_run = 1'b0;
    n = 0;
    idle = 0;
    req_valid <= 1'b1;
    req_write <= 1'b1;
    req_excl  <= 1'b0;
    req_addr  <= FILL;
    req_wdata <= fill_d(0);
    while (idle < 8 && n < 40) begin
      @(posedge pclk);
      if (req_ready === 1'b1) begin
        n++;
        idle = 0;
        req_addr  <= FILL + 32'(8 * n);
        req_wdata <= fill_d(n);
      end else begin
        idle++;
      end
    end
    req_valid <= 1'b0;
    chk("queue depth", 64'(n), 64'(ddrc_pkg::CMD_DEPTH));
    mclk_run = 1'b1;
    for (int k = 0; k < n; k++) mem_chk(FILL + 32'(8 * k), fill_d(k));
    // slow memory, stalled consumer: beats wait and come out in order
    slow = 1'b1;
    for (int k = 0; k < 6; k++) req_put(1'b0, 1'b0, 1'b0, FILL + 32'(8 * k), 64'h0);
    req_end();
    repeat (150) @(posedge pclk);
    chk("stalled beat held", rsp_valid, 1'b1);
    for (int k = 0; k < 6; k++) begin
      rsp_take(d);
      chk("read order", d, fill_d(k));
    end
    rsp_ready <= 1'b0;
    // second reset in mid-run clears the static wires
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    chk("rerst setup1", phy_setup1_bits, ddrc_pkg::SETUP_RST);
    chk("rerst freq", phy_freq_range_select, 3'b000);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    print_verdict();
  end
endmodule
`default_nettype wire
